// File: gupc_pkg.sv
// Shared constants for the gated up/down pulse counter
package gupc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LOAD = 8'h04;
    localparam logic [7:0] OFS_END = 8'h08;
    localparam logic [7:0] OFS_CMP = 8'h0C;
    localparam logic [7:0] OFS_COUNT = 8'h10;
    localparam logic [7:0] OFS_CAPT = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_CLEAR = 8'h1C;
    localparam logic [7:0] OFS_HYST = 8'h20;
    // Control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DIR_LSB = 2;
    localparam int CTRL_HWEN = 4;
    localparam int CTRL_STOP = 5;
    localparam int CTRL_SWGATE = 6;
    localparam int CTRL_CMPEN = 7;
    localparam int CTRL_WIDTH = 8;
    // Status field positions
    localparam int ST_OVF = 0;
    localparam int ST_UNF = 1;
    localparam int ST_CMP = 2;
    localparam int ST_IGATE = 3;
    localparam int ST_PGATE = 4;
    localparam int ST_ACLOSE = 5;
    localparam int CLR_BIT = 0;
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [31:0] VALUE_RESET = 32'h00000000;
    localparam logic [7:0] HYST_RESET = 8'h00;
    // Count limits
    localparam logic [31:0] COUNT_MAX = 32'h7FFFFFFF;
    localparam logic [31:0] COUNT_MIN = 32'h80000000;
    // Operating modes and main directions
    localparam logic [1:0] MODE_CONT = 2'h0;
    localparam logic [1:0] MODE_ONCE = 2'h1;
    localparam logic [1:0] MODE_PER = 2'h2;
    localparam logic [1:0] DIR_NONE = 2'h0;
    localparam logic [1:0] DIR_UP = 2'h1;
    localparam logic [1:0] DIR_DOWN = 2'h2;
    // Bus transfer state
    typedef enum logic [1:0] {GUPC_IDLE = 2'b01, GUPC_DATA = 2'b10} gupc_bus_e;
endpackage : gupc_pkg

// File: gupc_sync.sv
// Two-stage synchroniser bank for pin inputs
`timescale 1ns/10ps
module gupc_sync
    import gupc_pkg::*;
#(
    parameter int WIDTH = 4
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] sync
);
    initial
    begin
        if (WIDTH < 1)
        begin
            $error("gupc_sync needs WIDTH of at least one");
        end
    end
    logic [WIDTH-1:0] stage1;
    genvar i;
    // One synchroniser per pin
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    stage1[i] <= 1'b0;
                    sync[i] <= 1'b0;
                end
                else
                begin
                    stage1[i] <= pin[i];
                    sync[i] <= stage1[i];
                end
            end
        end
    endgenerate
endmodule : gupc_sync

// File: gupc_cmp.sv
// Comparator with hysteresis for the counter value
`timescale 1ns/10ps
module gupc_cmp
    import gupc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic enable,
    input wire logic [31:0] count,
    input wire logic [31:0] cmp_value,
    input wire logic [7:0] hyst,
    output logic flag
);
    logic hyst_active;
    logic [7:0] hyst_used;
    logic cond;
    logic signed [32:0] diff;
    logic outside;
    // Signed compare and distance from comparison value
    assign cond = $signed(count) >= $signed(cmp_value);
    assign diff = 33'($signed(count)) - 33'($signed(cmp_value));
    assign outside = (diff > $signed({25'h0000000, hyst_used})) || (diff < -$signed({25'h0000000, hyst_used}));
    // Range is latched at activation so later writes wait for the next event
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            flag <= 1'b0;
            hyst_active <= 1'b0;
            hyst_used <= HYST_RESET;
        end
        else if (!enable)
        begin
            flag <= 1'b0;
            hyst_active <= 1'b0;
        end
        else if (!hyst_active)
        begin
            flag <= cond;
            if (cond && !flag && (hyst > 8'h01))
            begin
                hyst_active <= 1'b1; // see [R23]
                hyst_used <= hyst;
            end
        end
        else if (outside)
        begin
            hyst_active <= 1'b0;
            flag <= cond;
        end
    end
endmodule : gupc_cmp

// File: gupc_counter.sv
// Gated up/down pulse counter channel with AHB-Lite registers
// Contract
// [R1] Continuous and undirected once/periodic modes start at load value, count both ways.
// [R2] Continuous: up pulse at upper limit wraps to lower limit.
// [R3] Continuous: down pulse at lower limit wraps to upper limit.
// [R4] Overflow/underflow set sticky flags, cleared only by clear-status request.
// [R5] Once, no direction: limit wrap also closes gate automatically and sets flag.
// [R6] Once, no direction: resume after reopening; stop keeps value, cancel reloads.
// [R7] Once, direction up: pulse after end minus one reloads and closes gate.
// [R8] Once, direction down: pulse after end plus one reloads and closes gate.
// [R9] Once with direction: restart only on gate rising edge, from load value.
// [R10] Upward end value accepted above lower limit; lower limit stays fixed.
// [R11] Periodic, no direction: limit wrap keeps counting, gate stays open.
// [R12] Periodic, direction up: pulse after end minus one reloads, keeps counting.
// [R13] Periodic, direction down: pulse after end plus one reloads, keeps counting.
// [R14] Internal gate combines pin gate and program gate; pin gate may be disabled.
// [R15] Pin gate opens on rising pin edge, closes on falling edge.
// [R16] Software opens program gate by setting its bit, closes by clearing.
// [R17] Cancel restarts from load value on reopening; stop continues last value.
// [R18] Pin gate disabled: program gate rising edge reloads in cancel, continues in stop.
// [R19] Pin gate on: program rise continues; pin rise with program set obeys cancel/stop.
// [R20] Once: auto-closed gate reopens on pin rise with program set, or later program rise.
// [R21] Latch rising edge while counting captures count; kept across stop/run.
// [R22] Comparison value held; comparison drives output and compare flag.
// [R23] New hysteresis range takes effect at next hysteresis event.
// [R24] Values are 32-bit signed; limits are extremes of that range.
//
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/10ps
module gupc_counter
    import gupc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic count_pulse_in,
    input wire logic count_dir_in,
    input wire logic pin_gate_in,
    input wire logic latch_in,
    output logic compare_out
);
    // Bus state
    gupc_bus_e bus_state;
    logic [7:0] req_addr;
    logic req_write;
    logic req_ok;
    // Registers
    logic [CTRL_WIDTH-1:0] ctrl;
    logic [31:0] load_value;
    logic [31:0] end_value;
    logic [31:0] cmp_value;
    logic [7:0] hyst;
    logic [31:0] count;
    logic [31:0] captured_count;
    logic overflow_flag;
    logic underflow_flag;
    logic compare_flag;
    logic auto_closed;
    logic pin_rise_seen;
    // Synchronised pins and edge history
    logic [3:0] pins_sync;
    logic pulse_q;
    logic pin_gate_q;
    logic latch_q;
    logic program_gate_q;
    // Decoded events
    logic [1:0] mode;
    logic [1:0] main_dir;
    logic hw_en;
    logic stop_fn;
    logic program_gate;
    logic pin_gate;
    logic igate;
    logic pulse_rise;
    logic pin_rise;
    logic latch_rise;
    logic program_rise;
    logic step_up;
    logic step_down;
    logic restart;
    logic reopen;
    logic hit_end_up;
    logic hit_end_down;
    logic wrap_up;
    logic wrap_down;
    logic bus_wr;
    logic clear_status_request;

    // Address decode shared by reads and writes
    function automatic logic addr_known(input logic [7:0] a);
        case (a)
            OFS_CTRL, OFS_LOAD, OFS_END, OFS_CMP, OFS_COUNT,
            OFS_CAPT, OFS_STATUS, OFS_CLEAR, OFS_HYST: addr_known = 1'b1;
            default: addr_known = 1'b0;
        endcase
    endfunction : addr_known

    // Pin synchronisers
    gupc_sync #(
        .WIDTH(4)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin({latch_in, pin_gate_in, count_dir_in, count_pulse_in}),
        .sync(pins_sync)
    );

    // Comparator with hysteresis
    gupc_cmp u_cmp (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(ctrl[CTRL_CMPEN]),
        .count(count),
        .cmp_value(cmp_value),
        .hyst(hyst),
        .flag(compare_flag)
    );

    // Field decode
    assign mode = ctrl[CTRL_MODE_LSB +: 2];
    assign main_dir = (mode == MODE_CONT) ? DIR_NONE : ctrl[CTRL_DIR_LSB +: 2];
    assign hw_en = ctrl[CTRL_HWEN];
    assign stop_fn = ctrl[CTRL_STOP];
    assign program_gate = ctrl[CTRL_SWGATE]; // see [R16]

    // Edge detection on synchronised pins and the program gate bit
    assign pulse_rise = pins_sync[0] && !pulse_q;
    assign pin_rise = hw_en && pins_sync[2] && !pin_gate_q;
    assign latch_rise = pins_sync[3] && !latch_q;
    assign program_rise = program_gate && !program_gate_q;

    // Internal gate
    assign pin_gate = hw_en ? pins_sync[2] : 1'b1; // see [R15]
    assign igate = pin_gate && program_gate && !auto_closed; // see [R14]

    // Restart from load value on gate reopening in cancel mode
    assign restart = !stop_fn && (hw_en ? (pin_rise && program_gate) : program_rise); // see [R17] [R18] [R19]

    // Reopen after automatic close in once mode
    assign reopen = hw_en ? ((pin_rise && program_gate) || (program_rise && pin_rise_seen))
                          : program_rise; // see [R20] [R6] [R9]

    // Count steps, direction pin low means up
    assign step_up = igate && pulse_rise && !pins_sync[1];
    assign step_down = igate && pulse_rise && pins_sync[1];
    assign hit_end_up = (main_dir == DIR_UP) && (count == 32'(end_value - 32'h00000001));
    assign hit_end_down = (main_dir == DIR_DOWN) && (count == 32'(end_value + 32'h00000001));
    assign wrap_up = step_up && !hit_end_up && (count == COUNT_MAX);
    assign wrap_down = step_down && !hit_end_down && (count == COUNT_MIN);

    // Bus write strobe in the data phase
    assign bus_wr = (bus_state == GUPC_DATA) && req_write && req_ok;
    assign clear_status_request = bus_wr && (req_addr == OFS_CLEAR) && hwdata[CLR_BIT];

    // AHB-Lite slave: one wait state on every transfer, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_state <= GUPC_IDLE;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            req_addr <= 8'h00;
            req_write <= 1'b0;
            req_ok <= 1'b0;
        end
        else
        begin
            case (bus_state)
                GUPC_IDLE:
                begin
                    if (hsel && htrans[1] && hready)
                    begin
                        bus_state <= GUPC_DATA;
                        hreadyout <= 1'b0;
                        req_addr <= haddr[7:0];
                        req_write <= hwrite;
                        req_ok <= (haddr[31:8] == 24'h000000) && addr_known(haddr[7:0]) && (hsize == 3'h2);
                    end
                end
                GUPC_DATA:
                begin
                    bus_state <= GUPC_IDLE;
                    hreadyout <= 1'b1;
                    hrdata <= 32'h00000000;
                    if (!req_write && req_ok)
                    begin
                        case (req_addr)
                            OFS_CTRL: hrdata <= {24'h000000, ctrl};
                            OFS_LOAD: hrdata <= load_value;
                            OFS_END: hrdata <= end_value;
                            OFS_CMP: hrdata <= cmp_value;
                            OFS_COUNT: hrdata <= count;
                            OFS_CAPT: hrdata <= captured_count;
                            OFS_STATUS: hrdata <= {26'h0000000, auto_closed, pin_gate, igate,
                                                   compare_flag, underflow_flag, overflow_flag};
                            OFS_HYST: hrdata <= {24'h000000, hyst};
                            default: hrdata <= 32'h00000000;
                        endcase
                    end
                end
                default:
                begin
                    bus_state <= GUPC_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // Parameter registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl <= CTRL_RESET;
            load_value <= VALUE_RESET;
            end_value <= VALUE_RESET;
            cmp_value <= VALUE_RESET;
            hyst <= HYST_RESET;
        end
        else if (bus_wr)
        begin
            case (req_addr)
                OFS_CTRL: ctrl <= hwdata[CTRL_WIDTH-1:0];
                OFS_LOAD: load_value <= hwdata;
                OFS_END:
                begin
                    if (!((ctrl[CTRL_DIR_LSB +: 2] == DIR_UP) && (hwdata == COUNT_MIN)))
                    begin
                        end_value <= hwdata; // see [R10]
                    end
                end
                OFS_CMP: cmp_value <= hwdata; // see [R22]
                OFS_HYST: hyst <= hwdata[7:0];
                default: ;
            endcase
        end
    end

    // Edge history registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pulse_q <= 1'b0;
            pin_gate_q <= 1'b0;
            latch_q <= 1'b0;
            program_gate_q <= 1'b0;
        end
        else
        begin
            pulse_q <= pins_sync[0];
            pin_gate_q <= pins_sync[2];
            latch_q <= pins_sync[3];
            program_gate_q <= program_gate;
        end
    end

    // Counter core: restart has priority over a count step
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count <= VALUE_RESET;
        end
        else if (restart)
        begin
            count <= load_value; // see [R1] [R17]
        end
        else if (step_up)
        begin
            if (hit_end_up)
            begin
                count <= load_value; // see [R7] [R12]
            end
            else if (count == COUNT_MAX)
            begin
                count <= COUNT_MIN; // see [R2] [R11] [R24]
            end
            else
            begin
                count <= 32'(count + 32'h00000001);
            end
        end
        else if (step_down)
        begin
            if (hit_end_down)
            begin
                count <= load_value; // see [R8] [R13]
            end
            else if (count == COUNT_MIN)
            begin
                count <= COUNT_MAX; // see [R3] [R11] [R24]
            end
            else
            begin
                count <= 32'(count - 32'h00000001);
            end
        end
    end

    // Automatic gate close in once mode and its reopening
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            auto_closed <= 1'b0;
            pin_rise_seen <= 1'b0;
        end
        else if (auto_closed)
        begin
            if (reopen || (mode != MODE_ONCE))
            begin
                auto_closed <= 1'b0; // see [R6] [R9] [R20]
                pin_rise_seen <= 1'b0;
            end
            else if (pin_rise)
            begin
                pin_rise_seen <= 1'b1;
            end
        end
        else if ((mode == MODE_ONCE) && !restart &&
                 ((step_up && hit_end_up) || (step_down && hit_end_down) || wrap_up || wrap_down))
        begin
            auto_closed <= 1'b1; // see [R5] [R7] [R8]
        end
    end

    // Sticky limit flags, a new event wins over a clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            overflow_flag <= 1'b0;
            underflow_flag <= 1'b0;
        end
        else
        begin
            overflow_flag <= (!restart && wrap_up) || (overflow_flag && !clear_status_request); // see [R4]
            underflow_flag <= (!restart && wrap_down) || (underflow_flag && !clear_status_request); // see [R4]
        end
    end

    // Latch capture while the gate is open
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            captured_count <= VALUE_RESET;
        end
        else if (latch_rise && igate)
        begin
            captured_count <= count; // see [R21]
        end
    end

    // Digital output follows the comparison result
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            compare_out <= 1'b0;
        end
        else
        begin
            compare_out <= compare_flag; // see [R22]
        end
    end

    // Checks
    sequence s_step_up;
        !restart && step_up;
    endsequence
    sequence s_step_down;
        !restart && step_down;
    endsequence

    a_wrap_upper: assert property (@(posedge hclk) disable iff (!hresetn) // see [R2]
        (s_step_up and (count == COUNT_MAX) && (mode == MODE_CONT)) |=> (count == COUNT_MIN) && overflow_flag)
        else $error("upper limit did not wrap");
    a_wrap_lower: assert property (@(posedge hclk) disable iff (!hresetn) // see [R3]
        (s_step_down and (count == COUNT_MIN) && (mode == MODE_CONT)) |=> (count == COUNT_MAX) && underflow_flag)
        else $error("lower limit did not wrap");
    a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // see [R4]
        overflow_flag && !clear_status_request |=> overflow_flag)
        else $error("overflow flag dropped without clear");
    a_once_close: assert property (@(posedge hclk) disable iff (!hresetn) // see [R5]
        (s_step_up and (count == COUNT_MAX) && (mode == MODE_ONCE) && (main_dir == DIR_NONE))
        |=> auto_closed && !igate && (count == COUNT_MIN))
        else $error("once mode did not close gate at limit");
    a_end_up: assert property (@(posedge hclk) disable iff (!hresetn) // see [R7] [R12]
        (s_step_up and hit_end_up) |=> (count == $past(load_value)) && (auto_closed == (mode == MODE_ONCE)))
        else $error("end value up did not reload");
    a_end_down: assert property (@(posedge hclk) disable iff (!hresetn) // see [R8] [R13]
        (s_step_down and hit_end_down) |=> (count == $past(load_value)))
        else $error("end value down did not reload");
    a_gate_hold: assert property (@(posedge hclk) disable iff (!hresetn) // see [R14]
        !igate && !restart |=> $stable(count))
        else $error("count moved with gate closed");
    a_cancel_load: assert property (@(posedge hclk) disable iff (!hresetn) // see [R17] [R18]
        restart |=> count == $past(load_value))
        else $error("cancel restart did not reload");
    a_latch_copy: assert property (@(posedge hclk) disable iff (!hresetn) // see [R21]
        latch_rise && igate |=> captured_count == $past(count))
        else $error("latch did not capture count");
    a_latch_keep: assert property (@(posedge hclk) disable iff (!hresetn) // see [R21]
        !(latch_rise && igate) |=> $stable(captured_count))
        else $error("captured count changed without latch");
endmodule : gupc_counter

// File: gupc_enc.sv
// Encoder, pin gate and latch model driving the counter pins
`timescale 1ns/10ps
module gupc_enc
(
    input wire logic hclk,
    output logic pulse,
    output logic dir,
    output logic gate,
    output logic latch
);
    // Quiet pins at time zero
    initial
    begin
        pulse = 1'b0;
        dir = 1'b0;
        gate = 1'b0;
        latch = 1'b0;
    end
    // One count pulse, direction set first and held throughout
    task automatic step(input logic d);
        @(posedge hclk);
        dir <= d;
        @(posedge hclk);
        pulse <= 1'b1;
        repeat (3) @(posedge hclk);
        pulse <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask : step
    // Gate level change, a rise opens and a fall closes the pin gate
    task automatic set_gate(input logic g);
        @(posedge hclk);
        gate <= g;
        repeat (6) @(posedge hclk);
    endtask : set_gate
    // Latch strobe, rising edge then back low
    task automatic strobe;
        @(posedge hclk);
        latch <= 1'b1;
        repeat (3) @(posedge hclk);
        latch <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask : strobe
endmodule : gupc_enc

// File: tb_gupc_counter.sv
// Self-checking bench for the gated up/down pulse counter
`timescale 1ns/10ps
module tb_gupc_counter
    import gupc_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic pulse, dir, gate, latch, compare_out;
    logic rd_phase = 1'b0;
    logic [31:0] exp_q[$];
    logic [7:0] adr_q[$];
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [31:0] r;
    assign hready = hreadyout;
    always #5 hclk = ~hclk;
    gupc_counter i_gupc_counter (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .count_pulse_in(pulse), .count_dir_in(dir),
        .pin_gate_in(gate), .latch_in(latch), .compare_out(compare_out));
    gupc_enc i_gupc_enc (.hclk(hclk), .pulse(pulse), .dir(dir), .gate(gate), .latch(latch));
    // Compare one value and count the outcome
    task automatic chk(input logic [7:0] name, input logic [31:0] seen, input logic [31:0] expv);
        n_checks++;
        if (seen !== expv)
        begin
            errors++;
            $display("[FAIL] reg %h exp %h seen %h", name, expv, seen);
        end
    endtask : chk
    // Verdict and end of run
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    // Single AHB-Lite word transfer; reads leave their expectation in the queue
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hsize <= 3'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_phase <= !w;
        if (!w)
        begin
            exp_q.push_back(e);
            adr_q.push_back(a);
        end
        do @(posedge hclk); while (hready !== 1'b1);
        rd_phase <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 32'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, e);
    endtask : rd
    // Control word from mode, direction, pin gate enable, stop and program gate
    function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] d, input logic h, input logic s,
        input logic g);
        return {24'h0, 1'b0, g, s, h, d, m};
    endfunction : ctl
    // Read monitor takes the oldest note when a read data phase ends
    always @(posedge hclk)
    begin
        if (rd_phase && hready === 1'b1 && exp_q.size() > 0)
        begin
            chk(adr_q.pop_front(), hrdata, exp_q.pop_front());
            chk(8'hFF, {31'h0, hresp}, 32'h0);
        end
    end
    // Hang guard
    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            errors++;
            conclude();
        end
    end
    // Main sequence
    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        r = $urandom(32'h37a32fc4);
        rd(OFS_CTRL, CTRL_RESET);
        rd(OFS_COUNT, VALUE_RESET);
        rd(OFS_STATUS, 32'h10);
        rd(8'h40, 32'h0);
        // Continuous wrap both ways with sticky flags
        wr(OFS_LOAD, 32'h7FFFFFFE);
        wr(OFS_CTRL, ctl(MODE_CONT, DIR_NONE, 1'b0, 1'b0, 1'b1));
        rd(OFS_COUNT, 32'h7FFFFFFE);
        i_gupc_enc.step(1'b0);
        i_gupc_enc.step(1'b0);
        rd(OFS_COUNT, COUNT_MIN);
        rd(OFS_STATUS, 32'h19);
        i_gupc_enc.step(1'b1);
        rd(OFS_COUNT, COUNT_MAX);
        rd(OFS_STATUS, 32'h1B);
        wr(OFS_CLEAR, 32'h1);
        rd(OFS_STATUS, 32'h18);
        // Stop function: closed gate ignores pulses, reopening keeps the value
        wr(OFS_CTRL, ctl(MODE_CONT, DIR_NONE, 1'b0, 1'b1, 1'b0));
        i_gupc_enc.step(1'b0);
        wr(OFS_CTRL, ctl(MODE_CONT, DIR_NONE, 1'b0, 1'b1, 1'b1));
        rd(OFS_COUNT, COUNT_MAX);
        // Once, upward, pin gate driven: end reload closes the gate
        wr(OFS_LOAD, 32'h3);
        wr(OFS_END, 32'h5);
        wr(OFS_CTRL, ctl(MODE_ONCE, DIR_UP, 1'b1, 1'b0, 1'b1));
        i_gupc_enc.set_gate(1'b1);
        rd(OFS_COUNT, 32'h3);
        i_gupc_enc.step(1'b0);
        i_gupc_enc.step(1'b0);
        rd(OFS_COUNT, 32'h3);
        rd(OFS_STATUS, 32'h30);
        i_gupc_enc.step(1'b0);
        rd(OFS_COUNT, 32'h3);
        i_gupc_enc.set_gate(1'b0);
        i_gupc_enc.set_gate(1'b1);
        i_gupc_enc.step(1'b0);
        rd(OFS_COUNT, 32'h4);
        i_gupc_enc.set_gate(1'b0);
        // Periodic, downward: end reload keeps counting, latch captures
        wr(OFS_LOAD, 32'h2);
        wr(OFS_END, 32'h0);
        wr(OFS_CTRL, ctl(MODE_PER, DIR_DOWN, 1'b0, 1'b0, 1'b0));
        wr(OFS_CTRL, ctl(MODE_PER, DIR_DOWN, 1'b0, 1'b0, 1'b1));
        i_gupc_enc.step(1'b1);
        i_gupc_enc.step(1'b1);
        rd(OFS_COUNT, 32'h2);
        i_gupc_enc.step(1'b1);
        i_gupc_enc.strobe();
        rd(OFS_CAPT, 32'h1);
        rd(OFS_STATUS, 32'h18);
        // Random load values in continuous cancel mode
        repeat (3)
        begin
            r = $urandom() & 32'h3FFFFFFF;
            wr(OFS_LOAD, r);
            wr(OFS_CTRL, ctl(MODE_CONT, DIR_NONE, 1'b0, 1'b0, 1'b0));
            wr(OFS_CTRL, ctl(MODE_CONT, DIR_NONE, 1'b0, 1'b0, 1'b1));
            i_gupc_enc.step(1'b1);
            rd(OFS_COUNT, r - 32'h1);
        end
        // Comparator drives the compare flag and the digital output
        wr(OFS_CMP, 32'h0);
        wr(OFS_CTRL, ctl(MODE_CONT, DIR_NONE, 1'b0, 1'b0, 1'b1) | 32'h80);
        rd(OFS_STATUS, 32'h1C);
        repeat (4) @(posedge hclk);
        chk(8'hFE, {31'h0, compare_out}, 32'h1);
        wr(OFS_CMP, COUNT_MAX);
        rd(OFS_STATUS, 32'h18);
        repeat (4) @(posedge hclk);
        chk(8'hFE, {31'h0, compare_out}, 32'h0);
        repeat (4) @(posedge hclk);
        conclude();
    end
endmodule : tb_gupc_counter
